// *** core/port_change_defines.vh ***
/*
 * Register offsets, field positions, reset values and codes for the
 * port state change detector.
 * Assumes a 32-bit APB slave with byte addresses and word registers.
 */
`ifndef PORT_CHANGE_DEFINES_VH
`define PORT_CHANGE_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets (shared and device side)
// ----------------------------------------------------------------------
`define OFS_ROLE_SELECT      12'h000
`define OFS_MAIN_IRQ_STATUS  12'h004
`define OFS_MAIN_IRQ_ENABLE  12'h008
`define OFS_DEV_IRQ_SUMMARY  12'h00c
`define OFS_DEV_IRQ_ENABLE   12'h010
`define OFS_DEV_STATUS       12'h014

// ----------------------------------------------------------------------
// host port blocks: base plus port times stride, then word offsets
// ----------------------------------------------------------------------
`define OFS_HOST_BASE        12'h020
`define HOST_STRIDE_SHIFT    5
`define HOST_PORT_BIT        5
`define HOST_WORD_MSB        4
`define HOST_WORD_LSB        2
`define HW_IRQ_SUMMARY       3'h0
`define HW_IRQ_ENABLE        3'h1
`define HW_USB_CONTROL       3'h2
`define HW_XCVR_CONTROL      3'h3
`define HW_USB_STATUS        3'h4
`define HW_STATE_CTRL        3'h5
`define OFS_HOST_END         12'h060

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_ROLE_HOST        0
`define BIT_MAIN_DEV         0
`define BIT_MAIN_HOST0       1
`define BIT_MAIN_HOST1       2
`define BIT_DEV_VBUS_CHG     0
`define BIT_DEV_HOST_VBUS_FAULT_STATE   0
`define BIT_LINE_CHG         0
`define BIT_HOST_VBUS_ERROR_FLAG         1
`define BIT_VBUS_ENABLE      0
`define BIT_FAULT_STATE      0
`define LINE_STATE_MSB       2
`define LINE_STATE_LSB       1
`define OP_MODE_MSB          1
`define OP_MODE_LSB          0

// ----------------------------------------------------------------------
// reset values and host state change codes
// ----------------------------------------------------------------------
`define XCVR_RESET           8'h00
`define XCVR_DETECT          8'h93
`define XCVR_OPERATE         8'h00
`define HSC_NONE             4'h0
`define HSC_OPERATE          4'h1
`define HSC_DETECT           4'h2
`define HSC_POWER_OFF        4'h3

`endif

// *** core/sticky_flag.v ***
/*
 * One sticky event flag with write-one-to-clear.
 * Assumes set and clear are single-clock qualified strobes.
 */
`timescale 1ns/1ns

module sticky_flag
(
    input  wire clock,
    input  wire resetn,
    input  wire set,      // hardware event
    input  wire clear,    // software clear strobe
    output reg  flag_q    // held flag
);

    // ------------------------------------------------------------------
    // flag register
    // ------------------------------------------------------------------
    // set wins so an event in the clearing cycle is kept
    always @(posedge clock)
    begin
        if (!resetn)
            flag_q <= 1'b0;
        else if (set)
            flag_q <= 1'b1;
        else if (clear)
            flag_q <= 1'b0;
    end

endmodule // sticky_flag

// *** core/level_change.v ***
/*
 * Change detector for a small synchronous input vector.
 * Assumes the input is already synchronous to clock.
 */
`timescale 1ns/1ns

module level_change
#(
    parameter WIDTH = 1
)
(
    input  wire             clock,
    input  wire             resetn,
    input  wire [WIDTH-1:0] level,     // sampled input
    output reg  [WIDTH-1:0] level_q,   // registered copy
    output wire             changed    // one-cycle pulse on change
);

    reg armed_q;   // first sample taken since reset

    // ------------------------------------------------------------------
    // sample register
    // ------------------------------------------------------------------
    // the first cycle after reset only loads, so reset itself is no change
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            level_q <= {WIDTH{1'b0}};
            armed_q <= 1'b0;
        end
        else
        begin
            level_q <= level;
            armed_q <= 1'b1;
        end
    end

    assign changed = armed_q && (level != level_q);

endmodule // level_change

// *** core/port_change_detect.v ***
/*
 * Port state change detector with APB register access: device VBUS
 * change on port 0, host VBUS fault and line change on both host ports,
 * power switch enables, transceiver mode and summary bits.
 * Assumes all pins are synchronous to clock and one APB master.
 */
`timescale 1ns/1ns
`include "port_change_defines.vh"

// Operation
// - detection runs in sleep and active states
// - port 0 device mode: VBUS change sets flag
// - device VBUS flag gated by its enable
// - device Host_vbus_fault_state bit shows input level
// - host ports: power fault sets error flag
// - VBUS error flag gated by its enable
// - power switch pin follows VBUS enable
// - status bit shows current fault input
// - host ports: DP/DM change sets flag
// - line change flag gated by its enable
// - two-bit line state field; 01/10 attached
// - leaving SE0 on connect raises line flag
// - role select leaves transceiver and VBUS alone
// - state change code updates transceiver and VBUS
// - two-bit op mode drives transceiver mode
// - select 1 host, 0 device; port 1 host
module port_change_detect
#(
    parameter PORTS = 2   // host-capable ports
)
(
    input  wire                 clock,
    input  wire                 resetn,
    input  wire [11:0]          paddr,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output wire                 pready,
    output reg                  pslverr,
    input  wire                 port0_vbus_in,
    input  wire [PORTS-1:0]     power_fault_in,
    input  wire [2*PORTS-1:0]   host_line_state_in,
    output wire [PORTS-1:0]     power_switch_en_out,
    output wire [2*PORTS-1:0]   xcvr_op_mode,
    output wire                 host_device_select,
    output wire                 device_irq_out,
    output wire [PORTS-1:0]     host_irq_out
);

    // ------------------------------------------------------------------
    // shared state
    // ------------------------------------------------------------------
    reg                 role_q;           // 1 host, 0 device on port 0
    reg  [2:0]          main_en_q;        // main summary enables
    reg                 dev_vbus_en_q;    // device VBUS change enable
    wire                dev_vbus_level;   // registered VBUS level
    wire                dev_vbus_chg;     // VBUS edge pulse
    wire                dev_vbus_flag;    // sticky device flag
    wire                dev_summary;      // device summary bit
    wire [PORTS-1:0]    host_summary;     // host summary bits
    wire [PORTS-1:0]    host_mode;        // port acts as host
    wire [2:0]          main_status;      // main summary bits

    // per-port flattened views for the read mux
    wire [PORTS-1:0]    line_flag;
    wire [PORTS-1:0]    err_flag;
    wire [2*PORTS-1:0]  host_en_all;
    wire [PORTS-1:0]    vbus_en_all;
    wire [8*PORTS-1:0]  xcvr_all;
    wire [4*PORTS-1:0]  code_all;
    wire [2*PORTS-1:0]  line_all;
    wire [PORTS-1:0]    fault_all;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire        setup_phase;      // first cycle of a transfer
    wire        wr_en;            // write takes effect
    wire        in_host;          // address falls in a host block
    wire        host_port;        // host block index
    wire [2:0]  host_word;        // word inside host block
    wire        mapped;           // address decodes to a register

    assign pready      = 1'b1;   // zero wait states, reads prefetched
    assign setup_phase = psel && !penable;
    assign wr_en       = psel && penable && pwrite && mapped;
    assign in_host     = (paddr >= `OFS_HOST_BASE) && (paddr < `OFS_HOST_END);
    assign host_port   = !paddr[`HOST_PORT_BIT];  // host base has this bit set
    assign host_word   = paddr[`HOST_WORD_MSB:`HOST_WORD_LSB];
    assign mapped      = (paddr[1:0] == 2'h0) &&
                         ((paddr <= `OFS_DEV_STATUS) ||
                          (in_host && host_word <= `HW_STATE_CTRL));

    // write strobes for shared registers
    wire wr_role     = wr_en && (paddr == `OFS_ROLE_SELECT);
    wire wr_main_en  = wr_en && (paddr == `OFS_MAIN_IRQ_ENABLE);
    wire wr_dev_sum  = wr_en && (paddr == `OFS_DEV_IRQ_SUMMARY);
    wire wr_dev_en   = wr_en && (paddr == `OFS_DEV_IRQ_ENABLE);

    // ------------------------------------------------------------------
    // shared registers
    // ------------------------------------------------------------------
    // role switching only touches the select bit; transceiver and VBUS
    // settings of the port stay as firmware left them
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            role_q        <= 1'b0;
            main_en_q     <= 3'h0;
            dev_vbus_en_q <= 1'b0;
        end
        else
        begin
            if (wr_role)
                role_q <= pwdata[`BIT_ROLE_HOST];
            if (wr_main_en)
                main_en_q <= pwdata[2:0];
            if (wr_dev_en)
                dev_vbus_en_q <= pwdata[`BIT_DEV_VBUS_CHG];
        end
    end

    assign host_device_select = role_q;
    // port 0 hosts only when selected; later ports are always hosts
    assign host_mode[0] = role_q;

    // ------------------------------------------------------------------
    // device VBUS change on port 0
    // ------------------------------------------------------------------
    // no power state input gates this path: it runs whenever clocked
    level_change #(.WIDTH(1)) u_dev_vbus
    (
        .clock   (clock),
        .resetn  (resetn),
        .level   (port0_vbus_in),
        .level_q (dev_vbus_level),
        .changed (dev_vbus_chg)
    );

    sticky_flag u_dev_flag
    (
        .clock  (clock),
        .resetn (resetn),
        .set    (dev_vbus_chg && !role_q),
        .clear  (wr_dev_sum && pwdata[`BIT_DEV_VBUS_CHG]),
        .flag_q (dev_vbus_flag)
    );

    assign dev_summary = dev_vbus_flag && dev_vbus_en_q;

    // ------------------------------------------------------------------
    // host ports
    // ------------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PORTS; p = p + 1)
        begin : g_host
            reg        line_en_q;    // line change enable
            reg        err_en_q;     // VBUS error enable
            reg        vbus_en_q;    // power switch enable
            reg  [7:0] xcvr_q;       // transceiver control
            reg  [3:0] code_q;       // pending state change code
            wire [1:0] line_q;       // registered line state
            wire       line_chg;     // line change pulse
            wire       sel;          // this port addressed
            wire       wr_sum;
            wire       wr_ien;
            wire       wr_ctl;
            wire       wr_xcvr;
            wire       wr_code;

            if (p > 0)
            begin : g_fixed_host
                assign host_mode[p] = 1'b1;
            end

            assign sel     = in_host && (host_port == p);
            assign wr_sum  = wr_en && sel && (host_word == `HW_IRQ_SUMMARY);
            assign wr_ien  = wr_en && sel && (host_word == `HW_IRQ_ENABLE);
            assign wr_ctl  = wr_en && sel && (host_word == `HW_USB_CONTROL);
            assign wr_xcvr = wr_en && sel && (host_word == `HW_XCVR_CONTROL);
            assign wr_code = wr_en && sel && (host_word == `HW_STATE_CTRL);

            // any DP/DM transition, including leaving SE0 on attach
            level_change #(.WIDTH(2)) u_line
            (
                .clock   (clock),
                .resetn  (resetn),
                .level   (host_line_state_in[2*p+1:2*p]),
                .level_q (line_q),
                .changed (line_chg)
            );

            sticky_flag u_line_flag
            (
                .clock  (clock),
                .resetn (resetn),
                .set    (line_chg && host_mode[p]),
                .clear  (wr_sum && pwdata[`BIT_LINE_CHG]),
                .flag_q (line_flag[p])
            );

            // level-set: a clear while the fault persists is undone at once
            sticky_flag u_err_flag
            (
                .clock  (clock),
                .resetn (resetn),
                .set    (power_fault_in[p] && host_mode[p]),
                .clear  (wr_sum && pwdata[`BIT_HOST_VBUS_ERROR_FLAG]),
                .flag_q (err_flag[p])
            );

            // enables, VBUS drive, transceiver and state change code
            // a software write to a register beats a code in the same
            // cycle only for the enables; the code runs one cycle later
            always @(posedge clock)
            begin
                if (!resetn)
                begin
                    line_en_q <= 1'b0;
                    err_en_q  <= 1'b0;
                    vbus_en_q <= 1'b0;
                    xcvr_q    <= `XCVR_RESET;
                    code_q    <= `HSC_NONE;
                end
                else
                begin
                    if (wr_ien)
                    begin
                        line_en_q <= pwdata[`BIT_LINE_CHG];
                        err_en_q  <= pwdata[`BIT_HOST_VBUS_ERROR_FLAG];
                    end
                    if (wr_code)
                        code_q <= pwdata[3:0];
                    else
                        code_q <= `HSC_NONE;
                    case (code_q)
                        `HSC_OPERATE:
                        begin
                            xcvr_q    <= `XCVR_OPERATE;
                            vbus_en_q <= 1'b1;
                        end
                        `HSC_DETECT:
                        begin
                            xcvr_q    <= `XCVR_DETECT;
                            vbus_en_q <= 1'b1;
                        end
                        `HSC_POWER_OFF:
                        begin
                            xcvr_q    <= `XCVR_DETECT;
                            vbus_en_q <= 1'b0;
                        end
                        default:
                        begin
                            // unknown codes leave settings untouched
                            if (wr_ctl)
                                vbus_en_q <= pwdata[`BIT_VBUS_ENABLE];
                            if (wr_xcvr)
                                xcvr_q <= pwdata[7:0];
                        end
                    endcase
                end
            end

            assign line_all[2*p+1:2*p]  = line_q;
            assign fault_all[p]         = power_fault_in[p];
            assign host_en_all[2*p+1:2*p] = {err_en_q, line_en_q};
            assign vbus_en_all[p]       = vbus_en_q;
            assign xcvr_all[8*p+7:8*p]  = xcvr_q;
            assign code_all[4*p+3:4*p]  = code_q;
            assign power_switch_en_out[p] = vbus_en_q;
            assign xcvr_op_mode[2*p+1:2*p] =
                xcvr_q[`OP_MODE_MSB:`OP_MODE_LSB];
            assign host_summary[p] = (line_flag[p] && line_en_q) ||
                                     (err_flag[p] && err_en_q);
        end
    endgenerate

    // ------------------------------------------------------------------
    // main summary and outputs
    // ------------------------------------------------------------------
    assign main_status    = {host_summary[1], host_summary[0], dev_summary};
    assign device_irq_out = main_status[`BIT_MAIN_DEV] &&
                            main_en_q[`BIT_MAIN_DEV];
    assign host_irq_out   = host_summary &
                            {main_en_q[`BIT_MAIN_HOST1], main_en_q[`BIT_MAIN_HOST0]};

    // ------------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------------
    reg [31:0] rd_d;   // next read word

    always @*
    begin
        rd_d = 32'h0;
        if (in_host)
        begin
            case (host_word)
                `HW_IRQ_SUMMARY:
                    rd_d = {30'h0, err_flag[host_port], line_flag[host_port]};
                `HW_IRQ_ENABLE:
                    rd_d = {30'h0, host_en_all[2*host_port+1],
                            host_en_all[2*host_port]};
                `HW_USB_CONTROL:
                    rd_d = {31'h0, vbus_en_all[host_port]};
                `HW_XCVR_CONTROL:
                    rd_d = {24'h0, xcvr_all[8*host_port +: 8]};
                `HW_USB_STATUS:
                    rd_d = {29'h0, line_all[2*host_port +: 2],
                            fault_all[host_port]};
                `HW_STATE_CTRL:
                    rd_d = {28'h0, code_all[4*host_port +: 4]};
                default:
                    rd_d = 32'h0;
            endcase
        end
        else
        begin
            case (paddr)
                `OFS_ROLE_SELECT:     rd_d = {31'h0, role_q};
                `OFS_MAIN_IRQ_STATUS: rd_d = {29'h0, main_status};
                `OFS_MAIN_IRQ_ENABLE: rd_d = {29'h0, main_en_q};
                `OFS_DEV_IRQ_SUMMARY: rd_d = {31'h0, dev_vbus_flag};
                `OFS_DEV_IRQ_ENABLE:  rd_d = {31'h0, dev_vbus_en_q};
                `OFS_DEV_STATUS:      rd_d = {31'h0, dev_vbus_level};
                default:              rd_d = 32'h0;
            endcase
        end
    end

    // read word and error flag are settled before the access phase
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata  <= (pwrite || !mapped) ? 32'h0 : rd_d;
            pslverr <= !mapped;
        end
    end

endmodule // port_change_detect

// *** sim/usb_peer_model.sv ***
/* cable peer and external power switch for both ports.
   assumes the bench steers attach, host vbus and load shorts. */
`timescale 1ns/1ns
module usb_peer_model
#(
    parameter PORTS = 2   // host-capable ports
)
(
    input  wire             clock,
    input  wire [PORTS-1:0] attach,      // bench: device plugged in
    input  wire             vbus_host,   // bench: far host supplies vbus
    input  wire [PORTS-1:0] short_load,  // bench: overload on the cable
    input  wire [PORTS-1:0] switch_en,   // from the block
    output reg              port0_vbus = 1'b0,
    output reg  [PORTS-1:0] fault = '0,
    output reg  [2*PORTS-1:0] line = '0
);
    integer p;  // port index
    // --------
    // pins move just after an edge
    // --------
    always @(posedge clock)
    begin
        port0_vbus <= vbus_host;
        for (p = 0; p < PORTS; p = p + 1)
        begin
            // a switch that is off cannot report an overload
            fault[p] <= short_load[p] & switch_en[p];
            // attached full-speed device idles at J, else SE0
            line[2*p +: 2] <= attach[p] ? 2'b01 : 2'b00;
        end
    end
endmodule // usb_peer_model

// *** sim/port_change_detect_sva.sv ***
/* port-level checker for the port change detector.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`include "port_change_defines.vh"
module port_change_detect_sva
#(
    parameter PORTS = 2
)
(
    input wire                 clock,
    input wire                 resetn,
    input wire [11:0]          paddr,
    input wire                 psel,
    input wire                 penable,
    input wire                 pwrite,
    input wire                 port0_vbus_in,
    input wire [PORTS-1:0]     power_fault_in,
    input wire [2*PORTS-1:0]   host_line_state_in,
    input wire [PORTS-1:0]     power_switch_en_out,
    input wire [2*PORTS-1:0]   xcvr_op_mode,
    input wire                 host_device_select,
    input wire                 device_irq_out,
    input wire [PORTS-1:0]     host_irq_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // --------
    // helpers
    // --------
    wire wr_acc = psel & penable & pwrite;  // write takes effect here
    sequence s_role_wr;
        wr_acc && paddr == `OFS_ROLE_SELECT;
    endsequence
    // --------
    // assertions
    // --------
    a_switch_cause: assert property (
        $changed(power_switch_en_out) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("switch enable moved with no write");
    a_mode_cause: assert property (
        $changed(xcvr_op_mode) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("op mode moved with no write");
    a_role_cause: assert property (
        $changed(host_device_select) |-> $past(wr_acc && paddr == `OFS_ROLE_SELECT))
        else $error("role moved with no role write");
    a_role_keeps: assert property (
        s_role_wr |=> $stable(xcvr_op_mode) && $stable(power_switch_en_out))
        else $error("role write disturbed transceiver or switch");
    a_dev_hold: assert property (
        device_irq_out && !wr_acc |=> device_irq_out)
        else $error("device summary dropped by itself");
    a_host_hold: assert property (
        !wr_acc |=> (host_irq_out & $past(host_irq_out)) == $past(host_irq_out))
        else $error("host summary dropped by itself");
    a_dev_cause: assert property (
        $rose(device_irq_out) |->
            $past(port0_vbus_in) != $past(port0_vbus_in, 2) || $past(wr_acc))
        else $error("device summary rose with no cause");
    a_host_cause: assert property (
        |(host_irq_out & ~$past(host_irq_out)) |-> |$past(power_fault_in) ||
            $past(host_line_state_in) != $past(host_line_state_in, 2) || $past(wr_acc))
        else $error("host summary rose with no cause");
endmodule // port_change_detect_sva

bind port_change_detect port_change_detect_sva #(.PORTS(PORTS)) u_sva (
    .clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .port0_vbus_in(port0_vbus_in),
    .power_fault_in(power_fault_in), .host_line_state_in(host_line_state_in),
    .power_switch_en_out(power_switch_en_out), .xcvr_op_mode(xcvr_op_mode),
    .host_device_select(host_device_select), .device_irq_out(device_irq_out),
    .host_irq_out(host_irq_out));

// *** sim/port_change_detect_bench.sv ***
/* self-checking bench for the port change detector.
   assumes the peer model and checker are compiled first. */
`timescale 1ns/1ns
module port_change_detect_bench;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, vbus, devirq, role;
    wire  [1:0]  fault, sw, hirq;
    wire  [3:0]  line, mode;
    logic [1:0]  attach = 2'h0, short_load = 2'h0;
    logic        vbus_host = 1'b0;
    int          mismatches = 0, checked = 0;
    // rows: address, written value, value read back
    logic [11:0] ra [0:6] = '{12'h008, 12'h010, 12'h024, 12'h028, 12'h02c, 12'h04c, 12'h048};
    logic [8:0]  rw [0:6] = '{9'h7, 9'h1, 9'h3, 9'h1, 9'h193, 9'h93, 9'h1};
    logic [8:0]  re [0:6] = '{9'h7, 9'h1, 9'h3, 9'h1, 9'h93, 9'h93, 9'h1};
    // state codes and expected {switch0, 0, op mode0}
    logic [3:0]  cc [0:3] = '{4'h2, 4'h3, 4'h1, 4'h4};
    logic [31:0] cx [0:3] = '{32'h93, 32'h93, 32'h0, 32'h0};
    logic [3:0]  cs [0:3] = '{4'hb, 4'h3, 4'h8, 4'h8};

    always #50 clock = ~clock;

    port_change_detect u_port_change_detect (.clock(clock), .resetn(resetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_vbus_in(vbus),
        .power_fault_in(fault), .host_line_state_in(line), .power_switch_en_out(sw),
        .xcvr_op_mode(mode), .host_device_select(role), .device_irq_out(devirq),
        .host_irq_out(hirq));
    usb_peer_model u_usb_peer_model (.clock(clock), .attach(attach),
        .vbus_host(vbus_host), .short_load(short_load), .switch_en(sw),
        .port0_vbus(vbus), .fault(fault), .line(line));
    // --------
    // bus and compare tasks
    // --------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(negedge clock);
    endtask
    task automatic word_chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic pin_chk(input logic [3:0] g, input logic [3:0] x);
        word_chk({28'h0, g}, {28'h0, x});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        word_chk(rd, x);
    endtask
    task automatic settle;  // peer register plus flag latency
        repeat (3) @(posedge clock);
    endtask
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // --------
    // watchdog
    // --------
    initial
    begin
        repeat (5000) @(posedge clock);
        mismatches++;
        report_and_stop;
    end
    // --------
    // main sequence
    // --------
    initial
    begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            wr(ra[i], {23'h0, rw[i]});
            rdchk(ra[i], {23'h0, re[i]});
        end
        pin_chk({2'h0, sw}, 4'h3);
        pin_chk(mode, 4'hf);
        $display("test registers done");
        for (int i = 0; i < 4; i++)
        begin
            wr(12'h034, {28'h0, cc[i]});
            rdchk(12'h02c, cx[i]);
            pin_chk({sw[0], 1'b0, mode[1:0]}, cs[i]);
        end
        $display("test state codes done");
        wr(12'h010, 32'h0);
        vbus_host <= 1'b1;
        attach[0] <= 1'b1;
        settle;
        rdchk(12'h00c, 32'h1);
        pin_chk({3'h0, devirq}, 4'h0);
        rdchk(12'h020, 32'h0);
        wr(12'h010, 32'h1);
        pin_chk({3'h0, devirq}, 4'h1);
        wr(12'h00c, 32'h1);
        rdchk(12'h00c, 32'h0);
        pin_chk({3'h0, devirq}, 4'h0);
        rdchk(12'h014, 32'h1);
        vbus_host <= 1'b0;
        settle;
        rdchk(12'h00c, 32'h1);
        $display("test device vbus done");
        wr(12'h000, 32'h1);
        pin_chk({role, sw[0], mode[1:0]}, 4'hc);
        wr(12'h00c, 32'h1);
        vbus_host <= 1'b1;
        attach[0] <= 1'b0;
        settle;
        rdchk(12'h00c, 32'h0);
        rdchk(12'h020, 32'h1);
        wr(12'h020, 32'h3);
        $display("test role done");
        wr(12'h040, 32'h3);
        wr(12'h044, 32'h3);
        wr(12'h04c, 32'h93);
        wr(12'h048, 32'h1);
        attach[1] <= 1'b1;
        settle;
        rdchk(12'h040, 32'h1);
        pin_chk({2'h0, hirq}, 4'h2);
        rdchk(12'h050, 32'h2);
        wr(12'h044, 32'h2);
        pin_chk({2'h0, hirq}, 4'h0);
        short_load[1] <= 1'b1;
        settle;
        rdchk(12'h040, 32'h3);
        pin_chk({2'h0, hirq}, 4'h2);
        rdchk(12'h050, 32'h3);
        wr(12'h048, 32'h0);
        pin_chk({2'h0, sw}, 4'h1);
        wr(12'h040, 32'h3);
        rdchk(12'h040, 32'h0);
        $display("test host port done");
        rdchk(12'h100, 32'h0);
        pin_chk({3'h0, pslverr}, 4'h1);
        rdchk(12'h002, 32'h0);
        pin_chk({3'h0, pslverr}, 4'h1);
        $display("test refusals done");
        report_and_stop;
    end
endmodule // port_change_detect_bench
